/* shared/shift_sub_unpack_pkg.sv */
package shift_sub_unpack_pkg;

    localparam logic [7:0] ESCAPE_BYTE   = 8'h0F;
    localparam logic [7:0] OPC_SHI_WORDS = 8'h71;
    localparam logic [7:0] OPC_SHI_DWORD = 8'h72;
    localparam logic [7:0] OPC_SHI_QWORD = 8'h73;
    localparam logic [7:0] OPC_SHL_W     = 8'hF1;
    localparam logic [7:0] OPC_SHL_D     = 8'hF2;
    localparam logic [7:0] OPC_SHL_Q     = 8'hF3;
    localparam logic [7:0] OPC_SHRL_W    = 8'hD1;
    localparam logic [7:0] OPC_SHRL_D    = 8'hD2;
    localparam logic [7:0] OPC_SHRL_Q    = 8'hD3;
    localparam logic [7:0] OPC_SHRA_W    = 8'hE1;
    localparam logic [7:0] OPC_SHRA_D    = 8'hE2;
    localparam logic [7:0] OPC_SUB_B     = 8'hF8;
    localparam logic [7:0] OPC_SUB_W     = 8'hF9;
    localparam logic [7:0] OPC_SUB_D     = 8'hFA;
    localparam logic [7:0] OPC_SSUB_B    = 8'hE8;
    localparam logic [7:0] OPC_SSUB_W    = 8'hE9;
    localparam logic [7:0] OPC_USUB_B    = 8'hD8;
    localparam logic [7:0] OPC_USUB_W    = 8'hD9;
    localparam logic [7:0] OPC_ILVH_B    = 8'h68;
    localparam logic [7:0] OPC_ILVH_W    = 8'h69;
    localparam logic [7:0] OPC_ILVH_D    = 8'h6A;
    localparam logic [7:0] OPC_ILVL_B    = 8'h60;
    localparam logic [7:0] OPC_ILVL_W    = 8'h61;
    localparam logic [7:0] OPC_ILVL_D    = 8'h62;
    localparam logic [7:0] OPC_XOR       = 8'hEF;

    localparam logic [1:0] MOD_REGISTER  = 2'h3;
    localparam logic [2:0] IMM_SEL_SHL   = 3'h6;
    localparam logic [2:0] IMM_SEL_SAR   = 3'h4;
    localparam logic [2:0] IMM_SEL_SHR   = 3'h2;

    localparam logic [3:0] EXEC_LATENCY  = 4'h2;
    localparam logic [3:0] LOAD_PUSHBACK = 4'h2;
    localparam int         FILLER_LAT    = 2;
    localparam int         FILLER_RATE   = 3;

    typedef enum logic [3:0] {
        OP_NONE      = 4'h0,
        OP_SHL       = 4'h1,
        OP_SHR_LOGIC = 4'h2,
        OP_SHR_ARITH = 4'h3,
        OP_SUB_WRAP  = 4'h4,
        OP_SUB_SSAT  = 4'h5,
        OP_SUB_USAT  = 4'h6,
        OP_ILV_HIGH  = 4'h7,
        OP_ILV_LOW   = 4'h8,
        OP_XOR       = 4'h9
    } op_kind_t;

    typedef enum logic [1:0] {
        W_BYTE  = 2'h0,
        W_WORD  = 2'h1,
        W_DWORD = 2'h2,
        W_QWORD = 2'h3
    } elem_width_t;

    typedef enum logic [1:0] {
        F_REG = 2'h0,
        F_MEM = 2'h1,
        F_IMM = 2'h2
    } form_t;

    typedef enum logic [2:0] {
        ST_ACCEPT = 3'b001,
        ST_LOAD   = 3'b010,
        ST_ISSUE  = 3'b100
    } state_t;

    typedef struct packed {
        logic        legal;
        op_kind_t    kind;
        elem_width_t width;
        form_t       form;
    } decode_t;

endpackage : shift_sub_unpack_pkg

/* rtl/shift_sub_unpack_decode.sv */
// What this block does
// - immediate shifts: reg field 110 left, 100 arith right, 010 logic right; mod 11
// - immediate shift opcode 71h words, 72h dwords, 73h qword after 0Fh
// - register/memory-count left shift is F1h, F2h, F3h for word, dword, qword
// - register/memory-count logic right shift is D1h, D2h, D3h
// - register/memory-count arith right shift is E1h words, E2h dwords
// - wrapping subtract is F8h, F9h, FAh for byte, word, dword
// - signed saturating subtract E8h, E9h; unsigned saturating D8h, D9h
// - high interleave 68h, 69h, 6Ah with 64-bit memory operand
// - low interleave 60h, 61h, 62h for byte, word, dword
// - low interleave memory forms fetch only a 32-bit operand
// - packed exclusive-or is EFh, register and 64-bit memory forms
// - all single-path decoded, add or multiply pipe, latency 2
// - mod 11 is register form, any other mod reads memory, except immediate shifts 71h-73h, which fault
// - integer register number comes from modrm bits 2 to 0
// - memory-form latency counts execution only, not load time
// - flagged instructions also issue a two-cycle independent filler nop
// - filler nops run up to three per cycle on any resource
`timescale 1ns/1ps
`default_nettype none

module shift_sub_unpack_decode
    import shift_sub_unpack_pkg::*;
#(
    parameter logic [15:0] FILLER_OPS = 16'h0000
) (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        enable,
    input  wire logic        in_valid,
    output logic             in_ready,
    input  wire logic [7:0]  escape_byte,
    input  wire logic [7:0]  opcode_byte,
    input  wire logic [7:0]  modrm_byte,
    input  wire logic [7:0]  imm_byte,
    output logic             decode_fault,
    output logic             load_req,
    input  wire logic        load_ack,
    output logic             load_is_32,
    output logic             issue_valid,
    input  wire logic        issue_ready,
    output logic [3:0]       op_kind,
    output logic [1:0]       elem_width,
    output logic [1:0]       operand_form,
    output logic [2:0]       dest_mmreg,
    output logic [2:0]       src_reg,
    output logic [7:0]       shift_count,
    output logic             single_path_decode,
    output logic             fp_add_pipe,
    output logic             fp_multiply_pipe,
    output logic [3:0]       exec_latency,
    output logic [3:0]       dep_latency,
    output logic [2:0]       filler_slot_valid,
    output logic [1:0]       filler_done_count
);

    logic     rst_meta_q;
    logic     rst_sync_q;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    function automatic decode_t decode(input logic [7:0] esc,
                                       input logic [7:0] opc,
                                       input logic [7:0] modrm);
        decode_t d;
        logic    reg_mod;
        d       = '{legal: 1'b1, kind: OP_NONE, width: W_WORD, form: F_REG};
        reg_mod = (modrm[7:6] == MOD_REGISTER);
        d.form  = reg_mod ? F_REG : F_MEM;
        unique case (opc)
            OPC_SHI_WORDS, OPC_SHI_DWORD, OPC_SHI_QWORD: begin
                d.form = F_IMM;
                d.width = (opc == OPC_SHI_WORDS) ? W_WORD :
                          (opc == OPC_SHI_DWORD) ? W_DWORD : W_QWORD;
                if (modrm[5:3] == IMM_SEL_SHL) begin
                    d.kind = OP_SHL;
                end else if (modrm[5:3] == IMM_SEL_SHR) begin
                    d.kind = OP_SHR_LOGIC;
                end else if (modrm[5:3] == IMM_SEL_SAR && opc != OPC_SHI_QWORD) begin
                    d.kind = OP_SHR_ARITH;
                end else begin
                    d.legal = 1'b0;
                end
                if (!reg_mod) begin
                    d.legal = 1'b0;
                end
            end
            OPC_SHL_W, OPC_SHL_D, OPC_SHL_Q: begin
                d.kind  = OP_SHL;
                d.width = elem_width_t'(opc[1:0]);
            end
            OPC_SHRL_W, OPC_SHRL_D, OPC_SHRL_Q: begin
                d.kind  = OP_SHR_LOGIC;
                d.width = elem_width_t'(opc[1:0]);
            end
            OPC_SHRA_W, OPC_SHRA_D: begin
                d.kind  = OP_SHR_ARITH;
                d.width = elem_width_t'(opc[1:0]);
            end
            OPC_SUB_B, OPC_SUB_W, OPC_SUB_D: begin
                d.kind  = OP_SUB_WRAP;
                d.width = elem_width_t'(opc[1:0]);
            end
            OPC_SSUB_B, OPC_SSUB_W: begin
                d.kind  = OP_SUB_SSAT;
                d.width = elem_width_t'(opc[1:0]);
            end
            OPC_USUB_B, OPC_USUB_W: begin
                d.kind  = OP_SUB_USAT;
                d.width = elem_width_t'(opc[1:0]);
            end
            OPC_ILVH_B, OPC_ILVH_W, OPC_ILVH_D: begin
                d.kind  = OP_ILV_HIGH;
                d.width = elem_width_t'(opc[1:0]);
            end
            OPC_ILVL_B, OPC_ILVL_W, OPC_ILVL_D: begin
                d.kind  = OP_ILV_LOW;
                d.width = elem_width_t'(opc[1:0]);
            end
            OPC_XOR: begin
                d.kind  = OP_XOR;
                d.width = W_QWORD;
            end
            default: begin
                d.legal = 1'b0;
            end
        endcase
        if (esc != ESCAPE_BYTE) begin
            d.legal = 1'b0;
        end
        if (!d.legal) begin
            d.kind = OP_NONE;
        end
        return d;
    endfunction : decode

    // instruction holding state
    state_t      state_q;
    state_t      state_d;
    decode_t     dec_q;
    decode_t     dec_d;
    decode_t     dec_now;
    logic [7:0]  modrm_q;
    logic [7:0]  modrm_d;
    logic [7:0]  imm_q;
    logic [7:0]  imm_d;
    logic        fault_q;
    logic        fault_d;

    assign dec_now = decode(escape_byte, opcode_byte, modrm_byte);

    always_comb begin
        state_d = state_q;
        dec_d   = dec_q;
        modrm_d = modrm_q;
        imm_d   = imm_q;
        fault_d = 1'b0;
        unique case (state_q)
            ST_ACCEPT: begin
                if (in_valid) begin
                    dec_d   = dec_now;
                    modrm_d = modrm_byte;
                    imm_d   = imm_byte;
                    fault_d = !dec_now.legal;
                    if (dec_now.legal) begin
                        // a memory source is fetched before the op may issue
                        state_d = (dec_now.form == F_MEM) ? ST_LOAD : ST_ISSUE;
                    end
                end
            end
            ST_LOAD: begin
                if (load_ack) begin
                    state_d = ST_ISSUE;
                end
            end
            ST_ISSUE: begin
                if (issue_ready) begin
                    state_d = ST_ACCEPT;
                end
            end
            default: begin
                state_d = ST_ACCEPT;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            state_q <= ST_ACCEPT;
            dec_q   <= '{legal: 1'b0, kind: OP_NONE, width: W_BYTE, form: F_REG};
            modrm_q <= 8'h00;
            imm_q   <= 8'h00;
            fault_q <= 1'b0;
        end else if (enable) begin
            state_q <= state_d;
            dec_q   <= dec_d;
            modrm_q <= modrm_d;
            imm_q   <= imm_d;
            fault_q <= fault_d;
        end
    end

    // handshakes are gated by enable so a frozen block takes and gives nothing
    assign in_ready     = enable && (state_q == ST_ACCEPT);
    assign load_req     = enable && (state_q == ST_LOAD);
    assign issue_valid  = enable && (state_q == ST_ISSUE);
    assign decode_fault = fault_q;

    assign op_kind            = dec_q.kind;
    assign elem_width         = dec_q.width;
    assign operand_form       = dec_q.form;
    assign dest_mmreg         = (dec_q.form == F_IMM) ? modrm_q[2:0] : modrm_q[5:3];
    assign src_reg            = modrm_q[2:0];
    assign shift_count        = (dec_q.form == F_IMM) ? imm_q : 8'h00;
    assign load_is_32         = (dec_q.kind == OP_ILV_LOW);
    assign single_path_decode = dec_q.legal;
    assign fp_add_pipe        = dec_q.legal;
    assign fp_multiply_pipe   = dec_q.legal;
    // load time is excluded; the scheduler gets a padded figure to honour instead
    assign exec_latency       = EXEC_LATENCY;
    assign dep_latency        = (dec_q.form == F_MEM) ? EXEC_LATENCY + LOAD_PUSHBACK
                                                      : EXEC_LATENCY;

    // filler nops: counted, not queued, since they carry no dependencies
    logic [3:0]  pend_q;
    logic [3:0]  pend_d;
    // stage 0 is the slot cycle, stage FILLER_LAT the completion two cycles on
    logic [1:0]  fly_q [FILLER_LAT+1];
    logic [1:0]  fly_d [FILLER_LAT+1];
    logic [1:0]  take;
    logic        filler_new;

    assign filler_new = issue_valid && issue_ready && FILLER_OPS[dec_q.kind];

    always_comb begin
        take = (pend_q >= 4'(FILLER_RATE)) ? 2'(FILLER_RATE) : pend_q[1:0];
        pend_d = pend_q - 4'(take) + 4'(filler_new);
        fly_d[0] = take;
        for (int i = 1; i <= FILLER_LAT; i++) begin
            fly_d[i] = fly_q[i-1];
        end
        // a saturated count would drop nops, so stall fetch is not needed at this rate
        if (pend_q == 4'hF && !filler_new) begin
            pend_d = pend_q - 4'(take);
        end
    end

    always_ff @(posedge clock or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            pend_q <= 4'h0;
            for (int i = 0; i <= FILLER_LAT; i++) begin
                fly_q[i] <= 2'h0;
            end
        end else if (enable) begin
            pend_q <= pend_d;
            for (int i = 0; i <= FILLER_LAT; i++) begin
                fly_q[i] <= fly_d[i];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < FILLER_RATE; g++) begin : g_slot
            assign filler_slot_valid[g] = (fly_q[0] > 2'(g));
        end
    endgenerate

    assign filler_done_count = fly_q[FILLER_LAT];

endmodule : shift_sub_unpack_decode

`default_nettype wire

/* tb/decode_checker_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module decode_checker
    import shift_sub_unpack_pkg::*;
(
    input wire logic       clock,
    input wire logic       reset_n,
    input wire logic       enable,
    input wire logic       in_valid,
    input wire logic       in_ready,
    input wire logic [7:0] opcode_byte,
    input wire logic [7:0] modrm_byte,
    input wire logic       decode_fault,
    input wire logic       load_req,
    input wire logic       load_ack,
    input wire logic       load_is_32,
    input wire logic       issue_valid,
    input wire logic [3:0] op_kind,
    input wire logic [1:0] operand_form,
    input wire logic [2:0] src_reg,
    input wire logic       single_path_decode,
    input wire logic       fp_add_pipe,
    input wire logic       fp_multiply_pipe,
    input wire logic [3:0] exec_latency,
    input wire logic [3:0] dep_latency,
    input wire logic [2:0] filler_slot_valid,
    input wire logic [1:0] filler_done_count
);
    logic       acc;
    logic [7:0] modrm_q;
    assign acc = enable && in_valid && in_ready;
    // last accepted modrm, so held fields can be traced back to it
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            modrm_q <= 8'h00;
        end else if (acc) begin
            modrm_q <= modrm_byte;
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    lat_path_a:
        assert property (issue_valid |-> exec_latency == 4'h2 && single_path_decode
            && fp_add_pipe && fp_multiply_pipe) else $error("issue path or latency wrong");
    mem_pad_a:
        assert property (issue_valid && operand_form == F_MEM |-> dep_latency == 4'h4)
            else $error("memory pad wrong");
    load_first_a:
        assert property ($rose(issue_valid) && operand_form == F_MEM
            |-> $past(load_req && load_ack)) else $error("memory issue without load");
    reg_noload_a:
        assert property (acc && modrm_byte[7:6] == MOD_REGISTER |=> !load_req)
            else $error("register form loaded");
    mem_load_a:
        assert property (acc && modrm_byte[7:6] != MOD_REGISTER
            |=> load_req || decode_fault) else $error("memory form no load");
    imm_mod_a:
        assert property (acc && modrm_byte[7:6] != 2'h3 && opcode_byte inside {8'h71,
            8'h72, 8'h73} |=> decode_fault) else $error("immediate memory form taken");
    low32_a:
        assert property (load_req |-> load_is_32 == (op_kind == OP_ILV_LOW))
            else $error("load size wrong");
    src_reg_a:
        assert property (issue_valid |-> src_reg == modrm_q[2:0])
            else $error("source register wrong");
    filler_done_a:
        assert property (filler_done_count == $countones($past(filler_slot_valid, 2)))
            else $error("filler completion wrong");
    cover property (acc && modrm_byte[7:6] != 2'h3 ##1 load_req);
    cover property (decode_fault);
    cover property (filler_slot_valid != 3'h0);
endmodule : decode_checker
bind shift_sub_unpack_decode decode_checker chk (.clock(clock), .reset_n(reset_n),
    .enable(enable), .in_valid(in_valid), .in_ready(in_ready),
    .opcode_byte(opcode_byte), .modrm_byte(modrm_byte), .decode_fault(decode_fault),
    .load_req(load_req), .load_ack(load_ack), .load_is_32(load_is_32),
    .issue_valid(issue_valid), .op_kind(op_kind), .operand_form(operand_form),
    .src_reg(src_reg), .single_path_decode(single_path_decode),
    .fp_add_pipe(fp_add_pipe), .fp_multiply_pipe(fp_multiply_pipe),
    .exec_latency(exec_latency), .dep_latency(dep_latency),
    .filler_slot_valid(filler_slot_valid), .filler_done_count(filler_done_count));
`default_nettype wire

/* tb/pipe_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// load/store unit and execution pipes; stall sets how slow they answer
module pipe_partner (
    input  wire logic       clock,
    input  wire logic       load_req,
    input  wire logic       issue_valid,
    input  wire logic [3:0] stall,
    output logic            load_ack,
    output logic            issue_ready
);
    logic [3:0] wait_q = 4'h0;
    initial load_ack = 1'b0;
    initial issue_ready = 1'b0;
    // answers last one cycle only, so a design that samples late sees no ack
    always @(posedge clock) begin
        #1;
        load_ack = 1'b0;
        issue_ready = 1'b0;
        if (load_req || issue_valid) begin
            if (wait_q >= stall) begin
                load_ack = load_req;
                issue_ready = issue_valid && !load_req;
                wait_q = 4'h0;
            end else begin
                wait_q = wait_q + 4'h1;
            end
        end
    end
endmodule : pipe_partner
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import shift_sub_unpack_pkg::*;
    logic clock = 1'b0, reset_n = 1'b0, enable = 1'b1, in_valid = 1'b0;
    logic [7:0] escape_byte = 8'h00, opcode_byte = 8'h00, modrm_byte = 8'h00;
    logic [7:0] imm_byte = 8'h00, shift_count;
    logic [3:0] stall = 4'h0, op_kind, exec_latency, dep_latency;
    logic in_ready, decode_fault, load_req, load_ack, load_is_32, issue_valid;
    logic issue_ready, single_path_decode, fp_add_pipe, fp_multiply_pipe;
    logic [1:0] elem_width, operand_form, filler_done_count;
    logic [2:0] dest_mmreg, src_reg, filler_slot_valid;
    int bad_count = 0, total_checks = 0;
    // opcode, kind, width of every register or memory form
    logic [13:0] tbl [22] = '{{8'hF1, 6'h05}, {8'hF2, 6'h06}, {8'hF3, 6'h07},
        {8'hD1, 6'h09}, {8'hD2, 6'h0A}, {8'hD3, 6'h0B}, {8'hE1, 6'h0D}, {8'hE2, 6'h0E},
        {8'hF8, 6'h10}, {8'hF9, 6'h11}, {8'hFA, 6'h12}, {8'hE8, 6'h14}, {8'hE9, 6'h15},
        {8'hD8, 6'h18}, {8'hD9, 6'h19}, {8'h68, 6'h1C}, {8'h69, 6'h1D}, {8'h6A, 6'h1E},
        {8'h60, 6'h20}, {8'h61, 6'h21}, {8'h62, 6'h22}, {8'hEF, 6'h27}};
    always #5 clock = ~clock;
    shift_sub_unpack_decode #(.FILLER_OPS(16'h0010)) dut (.clock(clock),
        .reset_n(reset_n), .enable(enable), .in_valid(in_valid), .in_ready(in_ready),
        .escape_byte(escape_byte), .opcode_byte(opcode_byte), .modrm_byte(modrm_byte),
        .imm_byte(imm_byte), .decode_fault(decode_fault), .load_req(load_req),
        .load_ack(load_ack), .load_is_32(load_is_32), .issue_valid(issue_valid),
        .issue_ready(issue_ready), .op_kind(op_kind), .elem_width(elem_width),
        .operand_form(operand_form), .dest_mmreg(dest_mmreg), .src_reg(src_reg),
        .shift_count(shift_count), .single_path_decode(single_path_decode),
        .fp_add_pipe(fp_add_pipe), .fp_multiply_pipe(fp_multiply_pipe),
        .exec_latency(exec_latency), .dep_latency(dep_latency),
        .filler_slot_valid(filler_slot_valid), .filler_done_count(filler_done_count));
    pipe_partner far (.clock(clock), .load_req(load_req), .issue_valid(issue_valid),
        .stall(stall), .load_ack(load_ack), .issue_ready(issue_ready));
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic check(input string what, input logic [7:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic step;
        @(posedge clock);
        #1;
    endtask : step
    task automatic do_op(input logic [7:0] esc, opc, mrm, imm, output logic ld, flt);
        int n;
        n = 0;
        escape_byte = esc;
        opcode_byte = opc;
        modrm_byte = mrm;
        imm_byte = imm;
        in_valid = 1'b1;
        step();
        in_valid = 1'b0;
        flt = decode_fault;
        ld = 1'b0;
        while (!flt && !issue_valid && n < 40) begin
            ld |= load_req;
            step();
            n++;
        end
        // a fault leaves the decoder idle; skip a cycle before the next offer
        if (flt) step();
        if (n == 40) check("issue wait", 8'h00, 8'h01);
    endtask : do_op
    task automatic retire;
        int n;
        n = 0;
        while (issue_valid && n < 40) begin
            step();
            n++;
        end
    endtask : retire
    task automatic table_forms(input logic mem);
        logic ld, flt;
        logic [7:0] m;
        m = mem ? 8'h4E : 8'hD5;
        foreach (tbl[i]) begin
            stall = 4'(i % 4);
            do_op(ESCAPE_BYTE, tbl[i][13:6], m, 8'h00, ld, flt);
            check("fields", {op_kind, elem_width, operand_form}, {tbl[i][5:0], 1'b0, mem});
            check("regs", {2'h0, dest_mmreg, src_reg}, {2'h0, m[5:0]});
            check("path", {1'b0, single_path_decode, fp_add_pipe, fp_multiply_pipe, exec_latency}, 8'h72);
            check("load", {ld, load_is_32, dep_latency}, {mem, tbl[i][5:2] == 4'h8, mem ? 4'h4 : 4'h2});
            retire();
        end
    endtask : table_forms
    task automatic imm_forms;
        logic ld, flt;
        logic [3:0] k;
        for (int w = 1; w < 4; w++) begin
            for (int s = 0; s < 3; s++) begin
                k = (s == 0) ? 4'h1 : (s == 1) ? 4'h3 : 4'h2;
                do_op(ESCAPE_BYTE, 8'(8'h70 + w), {2'h3, 3'(6 - 2 * s), 3'h3}, 8'h1C, ld, flt);
                check("imm fault", {7'h00, flt}, {7'h00, w == 3 && s == 1});
                if (!flt) begin
                    check("imm fields", {op_kind, elem_width, operand_form}, {k, 2'(w), F_IMM});
                    check("imm count", shift_count, 8'h1C);
                    retire();
                end
            end
        end
        do_op(ESCAPE_BYTE, OPC_SHI_WORDS, 8'h73, 8'h1C, ld, flt);
        check("imm mem", {7'h00, flt}, 8'h01);
        do_op(8'h0E, OPC_SHL_W, 8'hD5, 8'h00, ld, flt);
        check("escape", {6'h00, flt, issue_valid}, 8'h02);
    endtask : imm_forms
    task automatic fillers(input logic [7:0] opc, input int exp_n);
        logic ld, flt;
        int first, done_at, slots;
        repeat (6) step();
        do_op(ESCAPE_BYTE, opc, 8'hD5, 8'h00, ld, flt);
        retire();
        first = -1;
        done_at = -1;
        slots = 0;
        for (int c = 0; c < 8; c++) begin
            slots += $countones(filler_slot_valid);
            if (first < 0 && filler_slot_valid != 3'h0) first = c;
            if (done_at < 0 && filler_done_count != 2'h0) done_at = c;
            step();
        end
        check("filler slots", 8'(slots), 8'(exp_n));
        if (exp_n > 0) check("filler lat", 8'(done_at - first), 8'(FILLER_LAT));
    endtask : fillers
    initial begin
        repeat (16) @(posedge clock);
        #1;
        reset_n = 1'b1;
        repeat (3) step();
        table_forms(1'b0);
        table_forms(1'b1);
        imm_forms();
        fillers(OPC_SUB_B, 1);
        fillers(OPC_XOR, 0);
        tally_and_finish();
    end
    // a run this size needs about 300 cycles
    initial begin
        #100000;
        bad_count++;
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
